// ==== logic/intr_agg_pkg.sv ====
// constants for the interrupt aggregator
package intr_agg_pkg;
    localparam int NUM_GROUPS  = 15;
    localparam int GROUP_FIRST = 8;
    localparam int WAKE_GROUP  = 22 - GROUP_FIRST;
    localparam int GRP_STRIDE  = 20;
    localparam logic [7:0] OFF_SOURCE = 8'h00;
    localparam logic [7:0] OFF_EN_SET = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_EN_CLR = 8'h0C;
    localparam logic [9:0] OFF_BLK_SET   = 10'h200;
    localparam logic [9:0] OFF_BLK_CLR   = 10'h204;
    localparam logic [9:0] OFF_BLK_STAT  = 10'h208;
    localparam logic [9:0] OFF_CTRL      = 10'h20C;
    localparam logic [9:0] OFF_WAKE_STAT = 10'h210;
    localparam int CTRL_DIRECT_BIT = 0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_IMPL = 32'hFFFF_FFFF;
endpackage : intr_agg_pkg

// ==== logic/intr_aggregator.sv ====
// interrupt aggregator with wishbone register access
// Functional notes
// - sources are grouped; each group has source, enable set, enable clear, result
// - one enable set per group; both enable ports read that same value
// - enable-set writes set chosen bits; enable-clear writes clear chosen bits
// - result bit is source AND enable
// - group interrupt is OR of results AND the group's block-select bit
// - direct-vector enable routes each result bit to its own vector
// - any enabled member raises its group's aggregated vector
// - soft interrupts have no direct vectors, only the aggregated path
// - all groups but the wake-only one raise interrupts from synchronised sources
// - enabled results feed priority logic producing the vector number
// - wake-capable sources drive wake events through a flop clocked by this clock
// - pin wakes only when its detection setting selects an edge mode
// - wake-only group starts fast clock without raising a processor interrupt
// - with no further interrupt the clock request falls and sleep resumes
// - reset and error exceptions bypass this block and stay unmaskable
// - the block drops its clock request when nothing is pending
// - core system reset returns all registers to defaults
// - the fast input clock drives all sequential logic
// - bits of absent sources act as reserved and read zero
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module intr_aggregator #(
    parameter logic [32*intr_agg_pkg::NUM_GROUPS-1:0] IMPL_MASK = {15{intr_agg_pkg::RST_IMPL}},
    parameter logic [32*intr_agg_pkg::NUM_GROUPS-1:0] SOFT_MASK = '0
) (
    // clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    // wishbone slave
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [9:0]                        wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [31:0]                       wb_dat_i,
    output logic      [31:0]                       wb_dat_o,
    output logic                                   wb_ack_o,
    // raw asynchronous sources and pin edge-mode qualifiers
    input  wire logic [32*intr_agg_pkg::NUM_GROUPS-1:0] src_event,
    input  wire logic [32*intr_agg_pkg::NUM_GROUPS-1:0] wake_capable,
    input  wire logic [32*intr_agg_pkg::NUM_GROUPS-1:0] pin_edge_mode,
    // processor side
    output logic [intr_agg_pkg::NUM_GROUPS-1:0]    group_irq,
    output logic [32*intr_agg_pkg::NUM_GROUPS-1:0] direct_irq,
    output logic                                   irq_valid,
    output logic [8:0]                             irq_vector,
    // power management
    output logic                                   wake_request,
    output logic                                   clock_required
);
    localparam int NG = intr_agg_pkg::NUM_GROUPS;
    localparam int NB = 32 * NG;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [NB-1:0] s1_ff, s2_ff, s3_ff, seen_ff;
    logic [NB-1:0] source_ff, enable_ff;
    logic [NG-1:0] blk_sel_ff;
    logic          direct_en_ff;
    logic [NB-1:0] result;
    logic [NB-1:0] rise;
    logic [NB-1:0] wake_src;
    logic [NB-1:0] src_clr, en_set, en_clr;
    logic [NG-1:0] grp_any;
    logic          req;
    logic [9:0]    grp_off [NG];

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    ////////////////////////////////////////////////////////////////////////////
    // three-stage synchroniser, each bit counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            seen_ff <= '0;
        end else begin
            s1_ff   <= src_event;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            // per bit: a source settling late must not hold back the others
            seen_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (seen_ff & (s2_ff ^ s3_ff));
        end
    end
    assign rise = s3_ff & s2_ff & ~seen_ff;

    ////////////////////////////////////////////////////////////////////////////
    // per-group write decode and state
    genvar g;
    generate
        for (g = 0; g < NG; g++) begin : gen_grp
            logic [31:0] wmask;
            logic        hit_src, hit_set, hit_clr;
            assign grp_off[g] = 10'(g * intr_agg_pkg::GRP_STRIDE);
            assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & wb_dat_i
                           & IMPL_MASK[32*g +: 32];
            assign hit_src = req & wb_we_i
                           & (wb_adr_i == grp_off[g] + 10'(intr_agg_pkg::OFF_SOURCE));
            assign hit_set = req & wb_we_i
                           & (wb_adr_i == grp_off[g] + 10'(intr_agg_pkg::OFF_EN_SET));
            assign hit_clr = req & wb_we_i
                           & (wb_adr_i == grp_off[g] + 10'(intr_agg_pkg::OFF_EN_CLR));
            assign src_clr[32*g +: 32] = hit_src ? wmask : 32'h0000_0000;
            assign en_set[32*g +: 32]  = hit_set ? wmask : 32'h0000_0000;
            assign en_clr[32*g +: 32]  = hit_clr ? wmask : 32'h0000_0000;
            assign result[32*g +: 32]  = source_ff[32*g +: 32]
                                       & enable_ff[32*g +: 32];
            assign grp_any[g] = |result[32*g +: 32];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            source_ff <= '0;
        end else begin
            // set wins over a clear in the same cycle
            source_ff <= ((source_ff & ~src_clr) | rise) & IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_ff <= '0;
        end else begin
            enable_ff <= (enable_ff | en_set) & ~en_clr & IMPL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // block select and control
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blk_sel_ff   <= '0;
            direct_en_ff <= 1'b0;
        end else if (req && wb_we_i) begin
            if (wb_adr_i == intr_agg_pkg::OFF_BLK_SET) begin
                blk_sel_ff <= blk_sel_ff | wb_dat_i[NG-1:0];
            end else if (wb_adr_i == intr_agg_pkg::OFF_BLK_CLR) begin
                blk_sel_ff <= blk_sel_ff & ~wb_dat_i[NG-1:0];
            end else if (wb_adr_i == intr_agg_pkg::OFF_CTRL && wb_sel_i[0]) begin
                direct_en_ff <= wb_dat_i[intr_agg_pkg::CTRL_DIRECT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor outputs, registered; exceptions never pass through here
    logic [NG-1:0] nxt_group_irq;
    logic [8:0]    nxt_vec;
    logic          nxt_valid;
    always_comb begin
        nxt_group_irq = grp_any & blk_sel_ff;
        nxt_group_irq[intr_agg_pkg::WAKE_GROUP] = 1'b0;
        nxt_valid = 1'b0;
        nxt_vec   = 9'h000;
        for (int i = NG - 1; i >= 0; i--) begin
            if (nxt_group_irq[i]) begin
                nxt_valid = 1'b1;
                nxt_vec   = 9'(i + intr_agg_pkg::GROUP_FIRST);
            end
        end
    end

    logic [NB-1:0] wake_grp_mask;
    generate
        for (g = 0; g < NG; g++) begin : gen_wmask
            assign wake_grp_mask[32*g +: 32] =
                (g == intr_agg_pkg::WAKE_GROUP) ? 32'h0000_0000 : 32'hFFFF_FFFF;
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            group_irq  <= '0;
            direct_irq <= '0;
            irq_valid  <= 1'b0;
            irq_vector <= 9'h000;
        end else begin
            group_irq  <= nxt_group_irq;
            direct_irq <= direct_en_ff ? (result & ~SOFT_MASK & wake_grp_mask)
                                       : '0;
            irq_valid  <= nxt_valid;
            irq_vector <= nxt_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake and clock request
    assign wake_src = src_event & wake_capable & pin_edge_mode & enable_ff;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_request   <= 1'b0;
            clock_required <= 1'b0;
        end else begin
            wake_request   <= |wake_src;
            // clock held only while work is pending, then released for sleep
            clock_required <= nxt_valid | (|(direct_en_ff ? result & wake_grp_mask : '0))
                            | (|result[32*intr_agg_pkg::WAKE_GROUP +: 32]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read and ack
    logic [31:0] rd;
    always_comb begin
        rd = intr_agg_pkg::RST_WORD;
        for (int i = 0; i < NG; i++) begin
            if (wb_adr_i == grp_off[i] + 10'(intr_agg_pkg::OFF_SOURCE)) begin
                rd = source_ff[32*i +: 32];
            end
            if (wb_adr_i == grp_off[i] + 10'(intr_agg_pkg::OFF_EN_SET) ||
                wb_adr_i == grp_off[i] + 10'(intr_agg_pkg::OFF_EN_CLR)) begin
                rd = enable_ff[32*i +: 32];
            end
            if (wb_adr_i == grp_off[i] + 10'(intr_agg_pkg::OFF_RESULT)) begin
                rd = result[32*i +: 32];
            end
        end
        if (wb_adr_i == intr_agg_pkg::OFF_BLK_SET || wb_adr_i == intr_agg_pkg::OFF_BLK_CLR ||
            wb_adr_i == intr_agg_pkg::OFF_BLK_STAT) begin
            rd = {{(32-NG){1'b0}}, blk_sel_ff};
        end
        if (wb_adr_i == intr_agg_pkg::OFF_CTRL) begin
            rd = {31'h0000_0000, direct_en_ff};
        end
        if (wb_adr_i == intr_agg_pkg::OFF_WAKE_STAT) begin
            rd = {30'h0000_0000, clock_required, wake_request};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= intr_agg_pkg::RST_WORD;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd : intr_agg_pkg::RST_WORD;
        end
    end
endmodule : intr_aggregator

// ==== bench/intr_agg_asserts.sv ====
// port checker for the interrupt aggregator
`timescale 1ns/1ps
module intr_agg_asserts (
    // clock and reset
    input wire logic                                    ref_clk,
    input wire logic                                    rst,
    // bus
    input wire logic                                    wb_cyc_i,
    input wire logic                                    wb_stb_i,
    input wire logic                                    wb_ack_o,
    input wire logic [31:0]                             wb_dat_o,
    // sources and outputs
    input wire logic [32*intr_agg_pkg::NUM_GROUPS-1:0]  wake_capable,
    input wire logic [32*intr_agg_pkg::NUM_GROUPS-1:0]  pin_edge_mode,
    input wire logic [intr_agg_pkg::NUM_GROUPS-1:0]     group_irq,
    input wire logic [32*intr_agg_pkg::NUM_GROUPS-1:0]  direct_irq,
    input wire logic                                    irq_valid,
    input wire logic [8:0]                              irq_vector,
    input wire logic                                    wake_request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_wake_grp_quiet: assert property (!group_irq[intr_agg_pkg::WAKE_GROUP])
        else $error("wake-only group raised interrupt");
    a_wake_no_direct: assert property (direct_irq[32*intr_agg_pkg::WAKE_GROUP +: 32] == 32'h0)
        else $error("wake-only group drove direct vector");
    a_vec_range: assert property (irq_valid |-> irq_vector >= 9'h008 && irq_vector <= 9'h015)
        else $error("vector out of range");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> group_irq == '0 && !irq_valid
        && !wb_ack_o && !wake_request) else $error("outputs active after reset");
    a_wake_cause: assert property (wake_request |-> $past(|(wake_capable & pin_edge_mode)))
        else $error("wake without edge mode");
endmodule : intr_agg_asserts
bind intr_aggregator intr_agg_asserts i_chk (.ref_clk(ref_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .wake_capable(wake_capable), .pin_edge_mode(pin_edge_mode), .group_irq(group_irq),
    .direct_irq(direct_irq), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .wake_request(wake_request));

// ==== bench/nvic_model.sv ====
// processor-side model that takes the aggregated vector
`timescale 1ns/1ps
module nvic_model (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // interrupt request
    input wire logic        irq_valid,
    input wire logic [8:0]  irq_vector,
    // observed state
    output logic     [8:0]  seen_vec_ff
);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seen_vec_ff <= 9'h000;
        end else if (irq_valid) begin
            seen_vec_ff <= irq_vector;
        end
    end
endmodule : nvic_model

// ==== bench/testbench.sv ====
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
module testbench;
    localparam int NB = 32 * intr_agg_pkg::NUM_GROUPS;
    logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic irq_valid, wake_request, clock_required;
    logic [9:0]    wb_adr_i;
    logic [3:0]    wb_sel_i;
    logic [31:0]   wb_dat_i, wb_dat_o, rd, bit_m, soft_m, res_m, d;
    logic [NB-1:0] src_event, wake_capable, pin_edge_mode, direct_irq;
    logic [14:0]   group_irq;
    logic [8:0]    irq_vector, seen_vec;
    int unsigned   src_m[15], en_m[15];
    int            mismatches, compares, cycles, g;

    intr_aggregator #(.SOFT_MASK(480'h8000_0000)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .src_event(src_event), .wake_capable(wake_capable), .pin_edge_mode(pin_edge_mode),
        .group_irq(group_irq), .direct_irq(direct_irq), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .wake_request(wake_request),
        .clock_required(clock_required));
    nvic_model i_nvic (.ref_clk(ref_clk), .rst(rst), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .seen_vec_ff(seen_vec));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] dat);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask : wb
    function automatic logic [9:0] ga(input int grp, input logic [7:0] off);
        return 10'(20 * grp) + {2'b00, off};
    endfunction : ga
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        {src_event, pin_edge_mode} = '0;
        wake_capable = '1;
        rst = 1'b1;
        void'($urandom(97779));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        wb(1'b0, 10'h3FC, 32'h0000_0000); chk(rd, 32'h0000_0000);
        for (int i = 0; i < 15; i++) begin
            wb(1'b0, ga(i, intr_agg_pkg::OFF_EN_CLR), 32'h0); chk(rd, 32'h0);
        end
        repeat (20) begin
            g = $urandom % 14;
            bit_m = 32'h1 << ($urandom % 32);
            soft_m = (g == 0) ? 32'h8000_0000 : 32'h0000_0000;
            d = $urandom | bit_m;
            wb(1'b1, ga(g, intr_agg_pkg::OFF_EN_SET), d); en_m[g] |= d;
            d = $urandom & ~bit_m;
            wb(1'b1, ga(g, intr_agg_pkg::OFF_EN_CLR), d); en_m[g] &= ~d;
            wb(1'b1, ga(g, intr_agg_pkg::OFF_EN_SET), 32'h0);
            wb(1'b0, ga(g, intr_agg_pkg::OFF_EN_SET), 32'h0); chk(rd, en_m[g]);
            wb(1'b0, ga(g, intr_agg_pkg::OFF_EN_CLR), 32'h0); chk(rd, en_m[g]);
            src_event[32*g +: 32] <= bit_m;
            repeat (8) @(posedge ref_clk);
            src_event <= '0;
            src_m[g] |= bit_m;
            res_m = src_m[g] & en_m[g];
            wb(1'b1, ga(g, intr_agg_pkg::OFF_RESULT), 32'hFFFF_FFFF);
            wb(1'b0, ga(g, intr_agg_pkg::OFF_SOURCE), 32'h0); chk(rd, src_m[g]);
            wb(1'b0, ga(g, intr_agg_pkg::OFF_RESULT), 32'h0); chk(rd, res_m);
            wb(1'b1, intr_agg_pkg::OFF_CTRL, 32'h1);
            repeat (3) @(posedge ref_clk);
            chk(direct_irq[32*g +: 32], res_m & ~soft_m);
            wb(1'b1, intr_agg_pkg::OFF_CTRL, 32'h0);
            wb(1'b1, intr_agg_pkg::OFF_BLK_SET, 32'h1 << g);
            repeat (3) @(posedge ref_clk);
            chk({31'h0, group_irq[g]}, 32'h1);
            chk({23'h0, seen_vec}, 32'(8 + g));
            wb(1'b1, intr_agg_pkg::OFF_BLK_CLR, 32'h1 << g);
            wb(1'b1, ga(g, intr_agg_pkg::OFF_SOURCE), 32'hFFFF_FFFF); src_m[g] = 0;
        end
        g = intr_agg_pkg::WAKE_GROUP;
        wb(1'b1, ga(g, intr_agg_pkg::OFF_EN_SET), 32'h8);
        wb(1'b1, intr_agg_pkg::OFF_BLK_SET, 32'h4000);
        src_event[32*g+3] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({31'h0, wake_request}, 32'h0);
        pin_edge_mode[32*g+3] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({31'h0, wake_request}, 32'h1);
        chk({17'h0, group_irq}, 32'h0);
        chk({31'h0, clock_required}, 32'h1);
        wb(1'b0, intr_agg_pkg::OFF_WAKE_STAT, 32'h0); chk(rd, 32'h3);
        src_event <= '0;
        repeat (8) @(posedge ref_clk);
        chk({31'h0, wake_request}, 32'h0);
        wb(1'b1, ga(g, intr_agg_pkg::OFF_SOURCE), 32'h8);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, clock_required}, 32'h0);
        wb(1'b0, intr_agg_pkg::OFF_WAKE_STAT, 32'h0); chk(rd, 32'h0);
        stop_test();
    end
endmodule : testbench
